// >>> hdl/smfs_pkg.sv
// package: modes, fault carriers, defaults and timing for the mode and fault supervisor
package smfs_pkg;

    localparam int CLK_MHZ          = 100;
    localparam int WDTO_MS          = 310;
    localparam int IDLE_MS          = 250;
    localparam int WDTO_CYCLES      = WDTO_MS * 1000 * CLK_MHZ;
    localparam int IDLE_CYCLES      = IDLE_MS * 1000 * CLK_MHZ;
    localparam int RETRY_GAP_CYCLES = 1000;
    localparam int RETRY_COUNT      = 3;
    localparam int WORD_BITS        = 16;
    localparam int WD_BIT_POS       = 15;
    localparam int CHANNELS         = 2;

    typedef enum logic [1:0] {SM_SLEEP, SM_NORMAL, SM_FAILSAFE} smfs_mode_type;

    typedef struct packed {
        logic oc;
        logic sc;
        logic ot;
        logic ol_on;
        logic ol_off;
        logic os;
        logic clk_fail;
    } smfs_chan_flt_type;

    typedef struct packed {
        smfs_chan_flt_type [CHANNELS-1:0] ch;
        logic                             uv;
        logic                             ov;
    } smfs_flt_type;

    typedef struct packed {
        logic                parallel;
        logic                wd_disable;
        logic                vdd_fail_en;
        logic                retry_en;
        logic                ov_en;
        logic                clk_fail_en;
        logic                ol_on_en;
        logic                ol_off_en;
        logic                os_en;
        logic [CHANNELS-1:0] dir_dis;
        logic [CHANNELS-1:0] on;
    } smfs_cfg_type;

    localparam smfs_cfg_type CFG_RESET = '{
        parallel:    1'h0,
        wd_disable:  1'h0,
        vdd_fail_en: 1'h0,
        retry_en:    1'h1,
        ov_en:       1'h1,
        clk_fail_en: 1'h1,
        ol_on_en:    1'h0,
        ol_off_en:   1'h0,
        os_en:       1'h0,
        dir_dis:     2'h0,
        on:          2'h0
    };

endpackage

// >>> hdl/smfs_spi_rx.sv
// serial word receiver on the link clock, hands each finished word over by a toggle
`timescale 1ns/1ps
`default_nettype none
module smfs_spi_rx
    import smfs_pkg::*;
(
    input  wire logic                 i_sclk,
    input  wire logic                 i_link_rst_n,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_mosi,
    output logic     [WORD_BITS-1:0]  o_word,
    output logic                      o_word_tgl
);

    localparam int BW = $clog2(WORD_BITS);

    logic [WORD_BITS-2:0] shift;
    logic [BW-1:0]        bit_cnt;

    // deselect clears the framing, so a broken frame never shifts the next one
    always_ff @(posedge i_sclk or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            shift   <= '0;
            bit_cnt <= '0;
        end
        else
        begin
            shift   <= {shift[WORD_BITS-3:0], i_mosi};
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // word is held until the next full word, long enough for the far side to sample it
    always_ff @(posedge i_sclk or negedge i_link_rst_n)
    begin
        if (!i_link_rst_n)
        begin
            o_word     <= '0;
            o_word_tgl <= 1'b0;
        end
        else if (!i_cs_n && bit_cnt == BW'(WORD_BITS - 1))
        begin
            o_word     <= {shift, i_mosi};
            o_word_tgl <= ~o_word_tgl;
        end
    end

endmodule // smfs_spi_rx
`default_nettype wire

// >>> hdl/smfs_supervisor.sv
// operating mode, watchdog, auto-retry and fault flag supervisor for a two-channel switch
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] sleep keeps channels off, serial link ignored
// [R2] sleep when reset pin and activity flags low
// [R3] start in sleep; settings held at defaults
// [R4] supply or watchdog failure enters fail-safe
// [R5] fail-safe entry delatches, resets settings, blocks writes
// [R6] reset-pin rise arms watchdog on toggle bit
// [R7] exit: word with bit set, then second word
// [R8] normal again: pin high, faults and settings reset
// [R9] enabled faults enter fault mode; default enables
// [R10] status pin real time; sticky fault bits
// [R11] channel turned off except for diagnostic faults
// [R12] voltage faults turn both channels off
// [R13] read clears bit only if gone, unlatched
// [R14] fault in fail-safe: settings stay reset
// [R15] in fail-safe: counter reset and delatch still act
// [R16] latchable fault: off, wait, retry turn-on
// [R17] cleared before retries end releases status pin
// [R18] persisting after retries exhausted latches channel
// [R19] delatch on fault-control rise or counter reset
// [R20] fault control: activity and enable, or on
// [R21] host idles input or toggles on bit
// [R22] delatch during retry turns on; power-on delatches
// [R23] activity flag drops after idle time
// [R24] fault term: latchable causes or enabled overvoltage
module smfs_supervisor
    import smfs_pkg::*;
#(
    parameter int WDTO_CYC  = WDTO_CYCLES,
    parameter int IDLE_CYC  = IDLE_CYCLES,
    parameter int RETRY_GAP = RETRY_GAP_CYCLES,
    parameter int RETRY_MAX = RETRY_COUNT
)
(
    input  wire logic                i_mclk,
    input  wire logic                i_rst_n,
    input  wire logic                i_sclk,
    input  wire logic                i_cs_n,
    input  wire logic                i_mosi,
    input  wire logic                i_host_reset_pin,
    input  wire logic [1:0]          i_in,
    input  wire logic                i_vdd_fail,
    input  wire smfs_flt_type        i_flt,
    input  wire smfs_cfg_type        i_cfg,
    input  wire logic                i_cfg_wr,
    input  wire logic [1:0]          i_read_fault,
    input  wire logic                i_read_status,
    input  wire logic [1:0]          i_retry_reset,
    output var smfs_mode_type        o_mode,
    output logic                     o_fault_mode,
    output logic [1:0]               o_ch_on,
    output logic                     o_failsafe_output_pin,
    output logic                     o_fault_status_pin_n,
    output var smfs_flt_type         o_fault_bits,
    output logic [1:0]               o_latched,
    output logic                     o_spi_access,
    output var smfs_cfg_type         o_cfg
);

    localparam int WDW = $clog2(WDTO_CYC + 1);
    localparam int IDW = $clog2(IDLE_CYC + 1);
    localparam int RGW = $clog2(RETRY_GAP + 1);
    localparam int RCW = $clog2(RETRY_MAX + 1);

    logic [1:0]           in_m, in_s, in_on, fc, fc_q, fc_low, delatch, rwait, latch_cause, en_flt;
    logic                 rst_m, rst_s, rst_q, vdd_m, vdd_s;
    smfs_flt_type         flt_m, flt_s, flt_set, flt_clr, flt_keep;
    logic [WORD_BITS-1:0] link_word;
    logic                 link_tgl, tgl_m, tgl_s, tgl_q, word_evt, wd_in, wd_last;
    logic                 wake, volt_off, fault_term, any_flt, failsafe_cond, exit_ok;
    logic                 enter_fs, leave_fs, wd_armed, exit_armed, wd_expire;
    logic [WDW-1:0]       wd_cnt;
    logic [IDW-1:0]       idle_cnt [2];
    logic [RGW-1:0]       timer [2];
    logic [RCW-1:0]       used [2];
    logic [RCW-1:0]       limit;
    smfs_mode_type        next_mode;
    smfs_cfg_type         cfg_keep;

    // pins and detector outputs are asynchronous to the device clock
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            in_m  <= 2'h0;
            in_s  <= 2'h0;
            rst_m <= 1'h0;
            rst_s <= 1'h0;
            rst_q <= 1'h0;
            vdd_m <= 1'h0;
            vdd_s <= 1'h0;
            flt_m <= '0;
            flt_s <= '0;
        end
        else
        begin
            in_m  <= i_in;
            in_s  <= in_m;
            rst_m <= i_host_reset_pin;
            rst_s <= rst_m;
            rst_q <= rst_s;
            vdd_m <= i_vdd_fail;
            vdd_s <= vdd_m;
            flt_m <= i_flt;
            flt_s <= flt_m;
        end
    end

    smfs_spi_rx u_rx
    (
        .i_sclk       (i_sclk),
        .i_link_rst_n (i_rst_n),
        .i_cs_n       (i_cs_n),
        .i_mosi       (i_mosi),
        .o_word       (link_word),
        .o_word_tgl   (link_tgl)
    );

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            tgl_m <= 1'h0;
            tgl_s <= 1'h0;
            tgl_q <= 1'h0;
        end
        else
        begin
            tgl_m <= link_tgl;
            tgl_s <= tgl_m;
            tgl_q <= tgl_s;
        end
    end

    assign word_evt = (tgl_s != tgl_q) && (o_mode != SM_SLEEP); // R1
    assign wd_in    = link_word[WD_BIT_POS];

    assign wake          = rst_s | (|in_on); // R2
    assign volt_off      = flt_s.uv | (flt_s.ov & o_cfg.ov_en);
    assign fault_term    = (|latch_cause) | (flt_s.ov & o_cfg.ov_en); // R24
    assign any_flt       = fault_term | (|en_flt); // R9
    assign wd_expire     = wd_armed && (o_mode == SM_NORMAL) && (wd_cnt == '0);
    assign failsafe_cond = (vdd_s & o_cfg.vdd_fail_en) | (wd_expire & !o_cfg.wd_disable); // R4
    assign exit_ok       = (o_mode == SM_FAILSAFE) && word_evt && exit_armed && (wd_cnt != '0); // R7
    assign enter_fs      = (o_mode == SM_NORMAL) && (next_mode == SM_FAILSAFE);
    assign leave_fs      = (o_mode == SM_FAILSAFE) && (next_mode == SM_NORMAL);
    assign limit         = o_cfg.retry_en ? RCW'(RETRY_MAX) : '0;

    always_comb
    begin
        next_mode = o_mode;
        if (!wake)
            next_mode = SM_SLEEP; // R2
        else
        begin
            unique case (o_mode)
                SM_SLEEP:    next_mode = SM_NORMAL;
                SM_NORMAL:   next_mode = failsafe_cond ? SM_FAILSAFE : SM_NORMAL;
                SM_FAILSAFE: next_mode = exit_ok ? SM_NORMAL : SM_FAILSAFE;
                default:     next_mode = SM_SLEEP;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_mode <= SM_SLEEP; // R3
        else
            o_mode <= next_mode;
    end

    // one counter serves the watchdog in normal mode and the exit window in fail-safe
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || next_mode == SM_SLEEP)
        begin
            wd_armed   <= 1'h0;
            exit_armed <= 1'h0;
            wd_cnt     <= '0;
            wd_last    <= 1'h0;
        end
        else if (o_mode == SM_FAILSAFE)
        begin
            wd_armed <= exit_ok;
            if (exit_ok)
            begin
                exit_armed <= 1'h0;
                wd_cnt     <= WDW'(WDTO_CYC);
                wd_last    <= wd_in;
            end
            else if (word_evt && wd_in)
            begin
                exit_armed <= 1'h1; // R7
                wd_cnt     <= WDW'(WDTO_CYC);
            end
            else if (exit_armed && wd_cnt != '0)
                wd_cnt <= wd_cnt - 1'b1;
            else
                exit_armed <= 1'h0;
        end
        else
        begin
            exit_armed <= 1'h0;
            if (word_evt)
                wd_last <= wd_in;
            if (rst_s && !rst_q && !vdd_s)
            begin
                wd_armed <= 1'h1; // R6
                wd_cnt   <= WDW'(WDTO_CYC);
            end
            else if (!rst_s)
                wd_armed <= 1'h0;
            else if (word_evt && wd_in != wd_last)
                wd_cnt <= WDW'(WDTO_CYC); // R6
            else if (wd_armed && wd_cnt != '0)
                wd_cnt <= wd_cnt - 1'b1;
        end
    end

    always_comb
    begin
        cfg_keep          = CFG_RESET;
        cfg_keep.parallel = o_cfg.parallel;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || o_mode == SM_SLEEP)
            o_cfg <= CFG_RESET; // R3
        else if (enter_fs || leave_fs)
            o_cfg <= cfg_keep; // R5
        else if (o_mode == SM_NORMAL && i_cfg_wr)
            o_cfg <= i_cfg; // R14
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_spi_access <= 1'h0;
        else
            o_spi_access <= (next_mode == SM_NORMAL); // R5
    end

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++)
        begin : g_ch
            assign latch_cause[c] = flt_s.ch[c].oc | flt_s.ch[c].sc | flt_s.ch[c].ot | flt_s.uv; // R16
            assign en_flt[c]      = (flt_s.ch[c].ol_on & o_cfg.ol_on_en) | (flt_s.ch[c].ol_off & o_cfg.ol_off_en)
                                  | (flt_s.ch[c].os & o_cfg.os_en) | (flt_s.ch[c].clk_fail & o_cfg.clk_fail_en);
            assign fc[c]          = (in_on[c] & !o_cfg.dir_dis[c]) | o_cfg.on[c]; // R20
            assign delatch[c]     = (fc[c] & !fc_q[c] & fc_low[c]) | (i_retry_reset[c] & o_cfg.retry_en); // R19

            // input stays active while high; falls idle after a quiet low stretch
            always_ff @(posedge i_mclk)
            begin
                if (!i_rst_n)
                begin
                    in_on[c]    <= 1'h0;
                    idle_cnt[c] <= '0;
                end
                else if (in_s[c])
                begin
                    in_on[c]    <= 1'h1;
                    idle_cnt[c] <= IDW'(IDLE_CYC);
                end
                else if (idle_cnt[c] != '0)
                    idle_cnt[c] <= idle_cnt[c] - 1'b1;
                else
                    in_on[c] <= 1'h0; // R23
            end

            always_ff @(posedge i_mclk)
            begin
                if (!i_rst_n)
                begin
                    fc_q[c]   <= 1'h0;
                    fc_low[c] <= 1'h0;
                end
                else
                begin
                    fc_q[c] <= fc[c];
                    if (!fc[c] && fc_q[c])
                        fc_low[c] <= 1'h1;
                    else if (fc[c] && !fc_q[c])
                        fc_low[c] <= 1'h0;
                end
            end

            // fail-safe entry is the only mode change that clears retry state
            always_ff @(posedge i_mclk)
            begin
                if (!i_rst_n || enter_fs)
                begin
                    o_latched[c] <= 1'h0; // R22
                    rwait[c]     <= 1'h0;
                    used[c]      <= '0;
                    timer[c]     <= '0;
                end
                else if (delatch[c] && (rwait[c] || (o_latched[c] && !latch_cause[c])))
                begin
                    o_latched[c] <= 1'h0; // R22
                    rwait[c]     <= 1'h0;
                    used[c]      <= '0;
                end
                else if (rwait[c])
                begin
                    if (timer[c] != '0)
                        timer[c] <= timer[c] - 1'b1;
                    else
                    begin
                        rwait[c] <= 1'h0;
                        if (latch_cause[c] && used[c] == limit)
                            o_latched[c] <= 1'h1; // R18
                        else if (used[c] != limit)
                            used[c] <= used[c] + 1'b1; // R15
                    end
                end
                else if (latch_cause[c] && !o_latched[c])
                begin
                    rwait[c] <= 1'h1; // R16
                    timer[c] <= RGW'(RETRY_GAP);
                end
            end

            always_ff @(posedge i_mclk)
            begin
                if (!i_rst_n || o_mode == SM_SLEEP)
                    o_ch_on[c] <= 1'h0; // R1
                else
                    o_ch_on[c] <= ((o_mode == SM_FAILSAFE) ? in_s[c] : ((in_s[c] & !o_cfg.dir_dis[c]) | o_cfg.on[c]))
                                  & !(flt_s.ch[c].oc | flt_s.ch[c].sc | flt_s.ch[c].ot) // R11
                                  & !volt_off & !rwait[c] & !o_latched[c]; // R12
            end

            always_comb
            begin
                flt_set.ch[c]          = flt_s.ch[c];
                flt_set.ch[c].ol_on    = flt_s.ch[c].ol_on & o_cfg.ol_on_en;
                flt_set.ch[c].ol_off   = flt_s.ch[c].ol_off & o_cfg.ol_off_en;
                flt_set.ch[c].os       = flt_s.ch[c].os & o_cfg.os_en;
                flt_set.ch[c].clk_fail = flt_s.ch[c].clk_fail & o_cfg.clk_fail_en;
                flt_clr.ch[c]          = {7{i_read_fault[c]}} & ~flt_s.ch[c]; // R13
                if (rwait[c] || o_latched[c])
                begin
                    flt_clr.ch[c].oc = 1'h0;
                    flt_clr.ch[c].sc = 1'h0;
                    flt_clr.ch[c].ot = 1'h0;
                end
                flt_keep.ch[c]    = '0;
                flt_keep.ch[c].oc = o_latched[c];
                flt_keep.ch[c].sc = o_latched[c];
                flt_keep.ch[c].ot = o_latched[c];
            end
        end
    endgenerate

    always_comb
    begin
        flt_set.uv  = flt_s.uv;
        flt_set.ov  = flt_s.ov & o_cfg.ov_en;
        flt_clr.uv  = i_read_status & !flt_s.uv & !(|rwait) & !(|o_latched); // R13
        flt_clr.ov  = i_read_status & !flt_s.ov;
        flt_keep.uv = |o_latched;
        flt_keep.ov = 1'h0;
    end

    // a cause present in the clearing cycle sets the bit again, so no event is lost
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || o_mode == SM_SLEEP)
            o_fault_bits <= '0; // R3
        else if (enter_fs)
            o_fault_bits <= flt_set; // R5
        else if (leave_fs)
            o_fault_bits <= (o_fault_bits & flt_keep) | flt_set; // R8
        else
            o_fault_bits <= (o_fault_bits & ~flt_clr) | flt_set; // R10
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_fault_status_pin_n  <= 1'h1;
            o_failsafe_output_pin <= 1'h1;
            o_fault_mode          <= 1'h0;
        end
        else
        begin
            o_fault_status_pin_n  <= !((o_mode != SM_SLEEP) && (any_flt || (|o_latched))); // R17
            o_failsafe_output_pin <= (next_mode != SM_FAILSAFE); // R8
            o_fault_mode          <= (o_mode != SM_SLEEP) && any_flt; // R9
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_sleep_off;
        o_mode == SM_SLEEP |=> o_ch_on == 2'h0;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("channel on in sleep"); // R1

    property p_sleep_entry;
        (o_mode != SM_SLEEP && !wake) |=> o_mode == SM_SLEEP ##1 o_cfg == CFG_RESET;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep with wake-up low"); // R2

    property p_vdd_fs;
        (o_mode == SM_NORMAL && wake && vdd_s && o_cfg.vdd_fail_en) |=> o_mode == SM_FAILSAFE && !o_failsafe_output_pin;
    endproperty
    a_vdd_fs: assert property (p_vdd_fs) else $error("supply failure did not enter fail-safe"); // R4

    property p_fs_reset;
        enter_fs |=> o_latched == 2'h0 && o_cfg.on == 2'h0 && o_cfg.parallel == $past(o_cfg.parallel);
    endproperty
    a_fs_reset: assert property (p_fs_reset) else $error("fail-safe entry did not reset"); // R5

    property p_wd_timeout;
        (wd_expire && !o_cfg.wd_disable && wake) |=> o_mode == SM_FAILSAFE;
    endproperty
    a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog timeout missed"); // R6

    property p_exit;
        (exit_ok && wake) |=> o_mode == SM_NORMAL ##0 o_failsafe_output_pin ##0 o_spi_access;
    endproperty
    a_exit: assert property (p_exit) else $error("fail-safe exit failed"); // R7

    property p_fs_nowrite;
        (o_mode == SM_FAILSAFE && $past(o_mode) == SM_FAILSAFE) |-> o_cfg == cfg_keep;
    endproperty
    a_fs_nowrite: assert property (p_fs_nowrite) else $error("settings changed in fail-safe"); // R14

    property p_status_pin;
        (o_mode != SM_SLEEP && any_flt) |=> !o_fault_status_pin_n;
    endproperty
    a_status_pin: assert property (p_status_pin) else $error("status pin not asserted"); // R10

    property p_volt_off;
        volt_off |=> o_ch_on == 2'h0;
    endproperty
    a_volt_off: assert property (p_volt_off) else $error("voltage fault left a channel on"); // R12

    property p_latch;
        (rwait[0] && timer[0] == '0 && latch_cause[0] && used[0] == limit && !delatch[0] && !enter_fs)
            |=> o_latched[0] ##1 !o_fault_status_pin_n;
    endproperty
    a_latch: assert property (p_latch) else $error("exhausted retry did not latch"); // R18

    c_wake: cover property (o_mode == SM_SLEEP ##1 o_mode == SM_NORMAL);
    c_fs_exit: cover property (o_mode == SM_FAILSAFE ##1 o_mode == SM_NORMAL);
    c_latched: cover property (!o_latched[0] ##1 o_latched[0]);

endmodule // smfs_supervisor
`default_nettype wire

// >>> verif/smfs_host_model.sv
// host side model: sends sixteen-bit words on the link, clock idles between frames
`timescale 1ns/1ps
`default_nettype none
module smfs_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // first bit out is the watchdog toggle bit; the caller alternates it
    task automatic send(input logic [15:0] w);
        int i;
        o_cs_n = 1'b0;
        for (i = 15; i >= 0; i--)
        begin
            o_mosi = w[i];
            #6 o_sclk = 1'b1;
            #6 o_sclk = 1'b0;
        end
        #6 o_cs_n = 1'b1;
        // released line must not keep the last bit
        o_mosi = ~o_mosi;
        #12; // gap keeps the deselect visible between back-to-back words
    endtask
endmodule // smfs_host_model
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the mode and fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb
    import smfs_pkg::*;
;
    logic          i_mclk, i_rst_n, hrst, vdd_fail, cfg_wr, rd_st;
    logic [1:0]    in, rd_flt, rr;
    wire logic     sclk, cs_n, mosi;
    smfs_flt_type  flt, f, bits;
    smfs_cfg_type  cfg, c, o_cfg;
    smfs_mode_type mode;
    logic          fmode, fsp, stat_n, spi;
    logic [1:0]    ch_on, latched;
    int            mismatches = 0, check_count = 0, cycles = 0, k;

    smfs_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
    // short counts keep the run brief; the long waits below are sized to them
    smfs_supervisor #(.WDTO_CYC(200), .IDLE_CYC(100), .RETRY_GAP(20)) i_dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
        .i_host_reset_pin(hrst), .i_in(in), .i_vdd_fail(vdd_fail), .i_flt(flt), .i_cfg(cfg),
        .i_cfg_wr(cfg_wr), .i_read_fault(rd_flt), .i_read_status(rd_st), .i_retry_reset(rr),
        .o_mode(mode), .o_fault_mode(fmode), .o_ch_on(ch_on), .o_failsafe_output_pin(fsp),
        .o_fault_status_pin_n(stat_n), .o_fault_bits(bits), .o_latched(latched),
        .o_spi_access(spi), .o_cfg(o_cfg));

    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // settles one time unit past the edge so outputs are stable when sampled
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic pulse(input logic [1:0] rf, input logic [1:0] rs);
        @(posedge i_mclk);
        rd_flt <= rf;
        rr <= rs;
        @(posedge i_mclk);
        rd_flt <= 2'h0;
        rr <= 2'h0;
    endtask

    task automatic wr_cfg(input smfs_cfg_type v);
        @(posedge i_mclk);
        cfg <= v;
        cfg_wr <= 1'b1;
        @(posedge i_mclk);
        cfg_wr <= 1'b0;
        tick(2);
    endtask

    initial
    begin
        i_rst_n = 1'b0; hrst = 1'b0; in = 2'h0; vdd_fail = 1'b0; flt = '0;
        cfg = CFG_RESET; cfg_wr = 1'b0; rd_st = 1'b0; rd_flt = 2'h0; rr = 2'h0;
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        tick(2);
        check("mode", mode, SM_SLEEP);
        check("cfg", o_cfg, CFG_RESET);
        check("pins", {fsp, stat_n}, 2'h3);
        i_host.send(16'h8000);
        tick(6);
        check("sleep_link", {mode, spi, ch_on}, {SM_SLEEP, 3'h0});
        $display("done sleep");
        @(posedge i_mclk) hrst <= 1'b1;
        tick(5);
        check("wake", {mode, spi, fsp}, {SM_NORMAL, 2'h3});
        c = CFG_RESET;
        c.parallel = 1'b1;
        c.ov_en = 1'b0;
        wr_cfg(c);
        check("cfg_wr", o_cfg, c);
        for (k = 0; k < 4; k++) i_host.send({k[0], 15'h0});
        tick(150);
        check("wd_hold", mode, SM_NORMAL);
        tick(80);
        check("wd_expire", {mode, fsp, spi}, {SM_FAILSAFE, 2'h0});
        c = CFG_RESET;
        c.parallel = 1'b1;
        check("fs_cfg", o_cfg, c);
        wr_cfg(~c);
        check("fs_block", o_cfg, c);
        @(posedge i_mclk) in <= 2'h1;
        tick(6);
        check("fs_in", ch_on, 2'h1);
        $display("done failsafe");
        i_host.send(16'h8000);
        i_host.send(16'h0000);
        tick(6);
        check("exit", {mode, fsp, spi}, {SM_NORMAL, 2'h3});
        check("exit_cfg", o_cfg, c);
        c.parallel = 1'b0;
        c.wd_disable = 1'b1;
        wr_cfg(c);
        @(posedge i_mclk) in <= 2'h3;
        tick(6);
        check("on", ch_on, 2'h3);
        $display("done exit");
        f = '0;
        f.ch[0].oc = 1'b1;
        @(posedge i_mclk) flt <= f;
        tick(5);
        check("oc", {ch_on, stat_n, bits.ch[0].oc}, 4'h9);
        @(posedge i_mclk) flt <= '0;
        tick(40);
        check("oc_gone", {ch_on, stat_n, bits.ch[0].oc}, 4'hf);
        pulse(2'h1, 2'h0);
        tick(2);
        check("oc_read", bits, 16'h0);
        $display("done retry");
        @(posedge i_mclk) flt <= f;
        tick(150);
        check("latch", {latched, stat_n}, 3'h2);
        @(posedge i_mclk) flt <= '0;
        tick(6);
        pulse(2'h1, 2'h0);
        tick(2);
        check("latch_hold", {latched, stat_n, bits.ch[0].oc}, 4'h5);
        pulse(2'h0, 2'h1);
        tick(30);
        check("delatch", {latched, stat_n, ch_on}, 5'h7);
        pulse(2'h1, 2'h0);
        tick(2);
        check("delatch_read", bits, 16'h0);
        $display("done latch");
        for (k = 0; k < 3; k++)
        begin
            f = '0;
            f.uv = (k == 0);
            f.ov = (k == 1);
            f.ch[1].ol_on = (k == 2);
            @(posedge i_mclk) flt <= f;
            tick(5);
            check("volt", {ch_on, fmode}, (k < 2) ? 3'h1 : 3'h6);
            @(posedge i_mclk) flt <= '0;
            tick(40);
            check("volt_gone", {ch_on, stat_n}, 3'h7);
            check("volt_bit", {bits.uv, bits.ov}, {k == 0, k == 1});
            @(posedge i_mclk) rd_st <= 1'b1;
            @(posedge i_mclk) rd_st <= 1'b0;
            tick(2);
            check("volt_read", {bits.uv, bits.ov}, 2'h0);
        end
        $display("done voltage");
        c.vdd_fail_en = 1'b1;
        wr_cfg(c);
        @(posedge i_mclk) vdd_fail <= 1'b1;
        tick(5);
        check("vdd_fs", {mode, fsp, spi}, {SM_FAILSAFE, 2'h0});
        $display("done supply failure");
        @(posedge i_mclk);
        vdd_fail <= 1'b0;
        hrst <= 1'b0;
        in <= 2'h0;
        tick(130);
        check("sleep", {mode, ch_on}, {SM_SLEEP, 2'h0});
        check("sleep_cfg", o_cfg, CFG_RESET);
        $display("done sleep entry");
        final_report();
    end
endmodule // tb
`default_nettype wire
